// [design/sep_pkg.sv]
package sep_pkg;
  // Array and page geometry
  localparam int          SEP_AW        = 12;
  localparam int          SEP_DW        = 8;
  localparam int          SEP_PAGE_W    = 5;
  localparam int          SEP_PAGE_N    = 32;
  // Opcodes
  localparam logic [7:0]  SEP_OP_SETWL  = 8'h06;
  localparam logic [7:0]  SEP_OP_CLRWL  = 8'h04;
  localparam logic [7:0]  SEP_OP_STATUS_READ_CMD   = 8'h05;
  localparam logic [7:0]  SEP_OP_STATUS_WRITE_CMD   = 8'h01;
  localparam logic [7:0]  SEP_OP_READ   = 8'h03;
  localparam logic [7:0]  SEP_OP_WRITE  = 8'h02;
  // Status register bit positions
  localparam int          SEP_SR_BUSY   = 0;
  localparam int          SEP_SR_WEL    = 1;
  localparam int          SEP_SR_BPLO   = 2;
  localparam int          SEP_SR_BPHI   = 3;
  localparam int          SEP_SR_HWPE   = 7;
  // Reset values
  localparam logic        SEP_WEL_RST   = 1'b0;
  localparam logic [1:0]  SEP_BP_RST    = 2'h0;
  localparam logic        SEP_HWPE_RST  = 1'b0;
  // Block protect encodings
  localparam logic [1:0]  SEP_BP_NONE   = 2'h0;
  localparam logic [1:0]  SEP_BP_QTR    = 2'h1;
  localparam logic [1:0]  SEP_BP_HALF   = 2'h2;
  localparam logic [1:0]  SEP_BP_ALL    = 2'h3;
  // Bit counter end values
  localparam logic [3:0]  SEP_OPC_LAST  = 4'h7;
  localparam logic [3:0]  SEP_ADDR_LAST = 4'hF;
  // Timing
  localparam int          SEP_CLK_NS    = 4;
  localparam int          SEP_T_WC_MS   = 5;
  localparam int          SEP_T_WC_CYC  = SEP_T_WC_MS * 1000000 / SEP_CLK_NS;
  localparam int          SEP_WC_W      = 21;
  // Synchroniser lanes
  localparam int          SEP_PIN_N     = 5;
  localparam int          SEP_PIN_CS    = 0;
  localparam int          SEP_PIN_SCK   = 1;
  localparam int          SEP_PIN_SI    = 2;
  localparam int          SEP_PIN_HOLD  = 3;
  localparam int          SEP_PIN_WP    = 4;
  localparam logic [4:0]  SEP_PIN_RST   = 5'h19;

  // Serial engine states, Gray along the write path OPC, ADDR, WDATA
  typedef enum logic [2:0] {
    SEP_ST_OPC   = 3'h0,
    SEP_ST_ADDR  = 3'h1,
    SEP_ST_WDATA = 3'h3,
    SEP_ST_RDATA = 3'h2,
    SEP_ST_SDATA = 3'h6,
    SEP_ST_RSTAT = 3'h7,
    SEP_ST_DONE  = 3'h5,
    SEP_ST_IGN   = 3'h4
  } sep_state_t;
endpackage : sep_pkg

// [design/sep_mem.sv]
`timescale 1ns/1ps
module sep_mem #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // Clock
  input  wire logic          i_clk,
  // Write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  // Read port
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);
  logic [DW-1:0] mem_ff [2**AW];

  // Cell programming
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_ff[i_waddr] <= i_wdata;
    end
  end

  // Registered read
  always_ff @(posedge i_clk) begin
    o_rdata <= mem_ff[i_raddr];
  end
endmodule : sep_mem

// [design/sep_eeprom_core.sv]
`timescale 1ns/1ps
module sep_eeprom_core
  import sep_pkg::*;
#(
  parameter int WC_CYC = SEP_T_WC_CYC
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_srst,
  // Serial link pins
  input  wire logic i_cs_n,
  input  wire logic i_sck,
  input  wire logic i_si,
  output logic      o_so,
  output logic      o_so_oe,
  // Control pins
  input  wire logic i_hold_n,
  input  wire logic i_wp_n
);
  logic [SEP_PIN_N-1:0]  pin_s1_ff;
  logic [SEP_PIN_N-1:0]  pin_s2_ff;
  logic                  cs_d_ff;
  logic                  sck_d_ff;
  logic                  cs_n;
  logic                  sck;
  logic                  si;
  logic                  hold_n;
  logic                  wp_n;
  logic                  active;
  logic                  sck_rise;
  logic                  sck_fall;
  logic                  cs_rise;
  sep_state_t            state_ff;
  logic [3:0]            bit_ff;
  logic [7:0]            shift_ff;
  logic [7:0]            nxt_shift;
  logic [SEP_AW-1:0]     addr_ff;
  logic                  got_ff;
  logic                  opc_end;
  logic                  byte_end;
  logic                  busy_ff;
  logic                  wel_ff;
  logic [1:0]            bp_ff;
  logic                  hwpe_ff;
  logic [7:0]            status;
  logic                  blk_prot;
  logic                  wr_go;
  logic                  sr_go;
  logic                  set_write_latch_cmd_go;
  logic                  clear_write_latch_cmd_stb;
  logic                  wopc_stb;
  logic                  wbyte_stb;
  logic [SEP_PAGE_N-1:0] bvld_ff;
  logic [7:0]            buf_ff [SEP_PAGE_N];
  logic                  prog_arr_ff;
  logic [SEP_AW-1-SEP_PAGE_W:0] page_ff;
  logic [SEP_WC_W-1:0]   wc_cnt_ff;
  logic                  wc_last;
  logic                  mem_we;
  logic [SEP_DW-1:0]     mem_rdata;
  logic                  drv_ff;
  logic                  out_state;
  logic [7:0]            tx_byte;

  // Two-flop synchronisers on all pins
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pin_s1_ff <= SEP_PIN_RST;
      pin_s2_ff <= SEP_PIN_RST;
    end else begin
      pin_s1_ff <= {i_wp_n, i_hold_n, i_si, i_sck, i_cs_n};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // Edge history of the synchronised select and clock
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cs_d_ff  <= 1'b1;
      sck_d_ff <= 1'b0;
    end else begin
      cs_d_ff  <= pin_s2_ff[SEP_PIN_CS];
      sck_d_ff <= pin_s2_ff[SEP_PIN_SCK];
    end
  end

  // Synchronised pin levels
  assign cs_n   = pin_s2_ff[SEP_PIN_CS];
  assign sck    = pin_s2_ff[SEP_PIN_SCK];
  assign si     = pin_s2_ff[SEP_PIN_SI];
  assign hold_n = pin_s2_ff[SEP_PIN_HOLD];
  assign wp_n   = pin_s2_ff[SEP_PIN_WP];

  // Clock edges count only while selected and not paused
  assign active   = !cs_n && hold_n;
  assign sck_rise = active && sck && !sck_d_ff;
  assign sck_fall = active && !sck && sck_d_ff;
  assign cs_rise  = cs_n && !cs_d_ff;

  // Incoming byte and counter end points
  assign nxt_shift = {shift_ff[6:0], si};
  assign opc_end   = sck_rise && (state_ff == SEP_ST_OPC) && (bit_ff == SEP_OPC_LAST);
  assign byte_end  = sck_rise && (bit_ff[2:0] == SEP_OPC_LAST[2:0]);

  // Opcode and data byte strobes seen at the eighth bit
  assign clear_write_latch_cmd_stb = opc_end && !busy_ff && (nxt_shift == SEP_OP_CLRWL);
  assign wopc_stb = opc_end && !busy_ff && (nxt_shift == SEP_OP_WRITE);
  assign wbyte_stb = byte_end && (state_ff == SEP_ST_WDATA);

  // Status image
  always_comb begin
    status              = 8'h00;
    status[SEP_SR_BUSY] = busy_ff;
    status[SEP_SR_WEL]  = wel_ff;
    status[SEP_SR_BPLO] = bp_ff[0];
    status[SEP_SR_BPHI] = bp_ff[1];
    status[SEP_SR_HWPE] = hwpe_ff;
  end

  // Block protection of the addressed page
  always_comb begin
    case (bp_ff)
      SEP_BP_NONE: blk_prot = 1'b0;
      SEP_BP_QTR:  blk_prot = (addr_ff[SEP_AW-1 -: 2] == 2'h3);
      SEP_BP_HALF: blk_prot = addr_ff[SEP_AW-1];
      SEP_BP_ALL:  blk_prot = 1'b1;
      default:     blk_prot = 1'b1;
    endcase
  end

  // Commit decisions taken on the closing select edge
  assign wr_go = cs_rise && (state_ff == SEP_ST_WDATA) && (bit_ff == 4'h0) && got_ff
                 && wel_ff && !blk_prot;
  assign sr_go = cs_rise && (state_ff == SEP_ST_SDATA) && (bit_ff == 4'h0) && got_ff
                 && wel_ff && !(hwpe_ff && !wp_n);
  assign set_write_latch_cmd_go = cs_rise && (state_ff == SEP_ST_DONE) && (shift_ff == SEP_OP_SETWL);

  // Serial engine: state and bit counter
  always_ff @(posedge i_clk) begin
    if (i_srst || cs_n) begin
      state_ff <= SEP_ST_OPC;
      bit_ff   <= 4'h0;
    end else if (sck_rise) begin
      case (state_ff)
        SEP_ST_OPC: begin
          bit_ff <= (bit_ff == SEP_OPC_LAST) ? 4'h0 : bit_ff + 4'h1;
          if (bit_ff == SEP_OPC_LAST) begin
            if (nxt_shift == SEP_OP_STATUS_READ_CMD) begin
              state_ff <= SEP_ST_RSTAT;
            end else if (busy_ff) begin
              state_ff <= SEP_ST_IGN;
            end else begin
              case (nxt_shift)
                SEP_OP_SETWL: state_ff <= SEP_ST_DONE;
                SEP_OP_CLRWL: state_ff <= SEP_ST_DONE;
                SEP_OP_STATUS_WRITE_CMD:  state_ff <= SEP_ST_SDATA;
                SEP_OP_READ:  state_ff <= SEP_ST_ADDR;
                SEP_OP_WRITE: state_ff <= SEP_ST_ADDR;
                default:      state_ff <= SEP_ST_IGN;
              endcase
            end
          end
        end
        SEP_ST_ADDR: begin
          bit_ff <= (bit_ff == SEP_ADDR_LAST) ? 4'h0 : bit_ff + 4'h1;
          if (bit_ff == SEP_ADDR_LAST) begin
            state_ff <= (shift_ff[6:0] == SEP_OP_READ[6:0]) ? SEP_ST_RDATA : SEP_ST_WDATA;
          end
        end
        SEP_ST_DONE: begin
          state_ff <= SEP_ST_IGN;
        end
        SEP_ST_IGN: begin
          bit_ff <= 4'h0;
        end
        default: begin
          bit_ff <= {1'b0, bit_ff[2:0] + 3'h1};
        end
      endcase
    end
  end

  // Input shift register; holds opcode through address phase
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      shift_ff <= 8'h00;
    end else if (sck_rise && state_ff != SEP_ST_ADDR) begin
      shift_ff <= nxt_shift;
    end
  end

  // Address pointer: load, page wrap on write, full wrap on read
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      addr_ff <= '0;
    end else if (sck_rise && state_ff == SEP_ST_ADDR) begin
      addr_ff <= {addr_ff[SEP_AW-2:0], si};
    end else if (wbyte_stb) begin
      addr_ff[SEP_PAGE_W-1:0] <= addr_ff[SEP_PAGE_W-1:0] + 5'h01;
    end else if (byte_end && state_ff == SEP_ST_RDATA) begin
      addr_ff <= addr_ff + 12'h001;
    end
  end

  // At least one whole data byte seen
  always_ff @(posedge i_clk) begin
    if (i_srst || cs_n) begin
      got_ff <= 1'b0;
    end else if (byte_end && (state_ff == SEP_ST_WDATA || state_ff == SEP_ST_SDATA)) begin
      got_ff <= 1'b1;
    end
  end

  // Page load buffer, one entry per byte slot
  for (genvar gi = 0; gi < SEP_PAGE_N; gi++) begin : g_buf
    always_ff @(posedge i_clk) begin
      if (i_srst) begin
        buf_ff[gi]  <= 8'h00;
        bvld_ff[gi] <= 1'b0;
      end else if (wopc_stb) begin
        bvld_ff[gi] <= 1'b0;
      end else if (wbyte_stb && addr_ff[SEP_PAGE_W-1:0] == SEP_PAGE_W'(gi)) begin
        buf_ff[gi]  <= nxt_shift;
        bvld_ff[gi] <= 1'b1;
      end
    end
  end

  // Self-timed write: busy, cycle counter, target page
  assign wc_last = (wc_cnt_ff == SEP_WC_W'(WC_CYC - 1));
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      busy_ff     <= 1'b0;
      wc_cnt_ff   <= '0;
      prog_arr_ff <= 1'b0;
      page_ff     <= '0;
    end else if (wr_go || sr_go) begin
      busy_ff     <= 1'b1;
      wc_cnt_ff   <= '0;
      prog_arr_ff <= wr_go;
      page_ff     <= addr_ff[SEP_AW-1:SEP_PAGE_W];
    end else if (busy_ff) begin
      busy_ff     <= !wc_last;
      wc_cnt_ff   <= wc_cnt_ff + SEP_WC_W'(1);
    end
  end

  // Copy loaded bytes into the array during the first cycles
  assign mem_we = busy_ff && prog_arr_ff && (wc_cnt_ff < SEP_WC_W'(SEP_PAGE_N))
                  && bvld_ff[wc_cnt_ff[SEP_PAGE_W-1:0]];

  sep_mem #(
    .AW (SEP_AW),
    .DW (SEP_DW)
  ) u_mem (
    .i_clk   (i_clk),
    .i_we    (mem_we),
    .i_waddr ({page_ff, wc_cnt_ff[SEP_PAGE_W-1:0]}),
    .i_wdata (buf_ff[wc_cnt_ff[SEP_PAGE_W-1:0]]),
    .i_raddr (addr_ff),
    .o_rdata (mem_rdata)
  );

  // Write enable latch
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wel_ff <= SEP_WEL_RST;
    end else if (set_write_latch_cmd_go) begin
      wel_ff <= 1'b1;
    end else if (clear_write_latch_cmd_stb || (busy_ff && wc_last)) begin
      wel_ff <= 1'b0;
    end
  end

  // Protect bits change only through an accepted status write
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bp_ff   <= SEP_BP_RST;
      hwpe_ff <= SEP_HWPE_RST;
    end else if (sr_go) begin
      bp_ff   <= {shift_ff[SEP_SR_BPHI], shift_ff[SEP_SR_BPLO]};
      hwpe_ff <= shift_ff[SEP_SR_HWPE];
    end
  end

  // Output source per state
  assign out_state = (state_ff == SEP_ST_RDATA) || (state_ff == SEP_ST_RSTAT);
  assign tx_byte   = (state_ff == SEP_ST_RDATA) ? mem_rdata : status;

  // Output bit shifted on falling clock edge
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_so <= 1'b0;
    end else if (sck_fall && out_state) begin
      o_so <= tx_byte[3'h7 - bit_ff[2:0]];
    end
  end

  // Driving starts at the first falling edge of an output phase
  always_ff @(posedge i_clk) begin
    if (i_srst || cs_n) begin
      drv_ff <= 1'b0;
    end else if (sck_fall && out_state) begin
      drv_ff <= 1'b1;
    end
  end

  // Output enable: off when deselected or paused
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_so_oe <= 1'b0;
    end else begin
      o_so_oe <= active && (drv_ff || (sck_fall && out_state));
    end
  end
endmodule : sep_eeprom_core

// [bench/sep_chk.sv]
`timescale 1ns/1ps
module sep_chk
  import sep_pkg::*;
#(
  parameter int WC_CYC = SEP_T_WC_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Link pins
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic o_so,
  input wire logic o_so_oe,
  // Control pins
  input wire logic i_hold_n,
  input wire logic i_wp_n
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  // Output floats while deselected or paused
  desel_float_a: assert property (i_cs_n [*5] |-> !o_so_oe)
    else $error("output driven while deselected");
  pause_float_a: assert property (!i_hold_n [*5] |-> !o_so_oe)
    else $error("output driven while paused");
  cs_release_a: assert property ($rose(i_cs_n) |-> ##[1:4] !o_so_oe)
    else $error("output not released after select rise");
  pause_release_a: assert property ($fell(i_hold_n) |-> ##[1:4] !o_so_oe)
    else $error("output not released after pause");
  sel_needed_a: assert property (o_so_oe |-> !$past(i_cs_n, 4))
    else $error("output driven without select");
  // Output data moves only after a clock fall
  so_on_fall_a: assert property (o_so_oe && $changed(o_so) |-> $past(i_sck, 6) && !$past(i_sck, 2))
    else $error("output bit changed away from clock fall");
  so_steady_a: assert property (o_so_oe && i_sck && $past(i_sck, 4) |-> $stable(o_so))
    else $error("output bit moved while clock high");
  // Enable rises on a clock fall, or on leaving a pause with the clock low
  oe_on_fall_a: assert property ($rose(o_so_oe) |-> !$past(i_cs_n, 2) && !$past(i_sck, 2)
    && ($past(i_sck, 6) || !$past(i_hold_n, 6)))
    else $error("output enabled away from clock fall");
endmodule : sep_chk

bind sep_eeprom_core sep_chk #(.WC_CYC(WC_CYC)) chk_u (.i_clk(i_clk), .i_srst(i_srst), .i_cs_n(i_cs_n),
  .i_sck(i_sck), .i_si(i_si), .o_so(o_so), .o_so_oe(o_so_oe), .i_hold_n(i_hold_n), .i_wp_n(i_wp_n));

// [bench/sep_host.sv]
`timescale 1ns/1ps
module sep_host (
  // Clock
  input  wire logic i_clk,
  // Device answer
  input  wire logic i_so,
  input  wire logic i_so_oe,
  // Link drive
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_si,
  output logic      o_hold_n
);
  logic so_w;
  bit   cpol = 1'b0; // Clock idles high when set (mode 3)

  // Pin level as the host sees it
  assign so_w = i_so_oe ? i_so : 1'bz;

  // Idle levels, clock stands at its mode's idle level outside frames
  initial begin
    o_cs_n   = 1'b1;
    o_sck    = 1'b0;
    o_si     = 1'b0;
    o_hold_n = 1'b1;
  end

  // Open a frame
  task automatic sel();
    @(negedge i_clk);
    o_sck  = cpol;
    repeat (4) @(negedge i_clk);
    o_cs_n = 1'b0;
    repeat (10) @(negedge i_clk);
  endtask : sel

  // Close a frame; data line flips once released
  task automatic desel();
    repeat (10) @(negedge i_clk);
    o_cs_n = 1'b1;
    o_si   = ~o_si;
    repeat (10) @(negedge i_clk);
  endtask : desel

  // One byte MSB first, mode 0 or 3, optional pause mid-byte in either mode
  task automatic bx(input logic [7:0] tx, input bit pz, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(negedge i_clk);
      o_sck = 1'b0;
      o_si  = tx[i];
      repeat (9) @(negedge i_clk);
      rx[i] = so_w;
      o_sck = 1'b1;
      repeat (10) @(negedge i_clk);
      if (!cpol) o_sck = 1'b0;
      if (pz && i == 4) begin
        repeat (4) @(negedge i_clk);
        o_hold_n = 1'b0;
        repeat (6) @(negedge i_clk);
        o_si = ~o_si;
        repeat (6) @(negedge i_clk);
        o_hold_n = 1'b1;
      end
    end
  endtask : bx
endmodule : sep_host

// [bench/spi_serial_eeprom_protocol_bench.sv]
`timescale 1ns/1ps
module spi_serial_eeprom_protocol_bench;
  import sep_pkg::*;
  localparam int WC = 2000;
  logic       clk;
  logic       srst;
  logic       wp_n;
  logic       cs_n;
  logic       sck;
  logic       si;
  logic       hold_n;
  logic       so;
  logic       so_oe;
  logic [7:0] s;
  logic [7:0] r;
  int         fails;
  int         tests_run;
  int         cyc;

  sep_eeprom_core #(.WC_CYC(WC)) dut_u (.i_clk(clk), .i_srst(srst), .i_cs_n(cs_n), .i_sck(sck),
    .i_si(si), .o_so(so), .o_so_oe(so_oe), .i_hold_n(hold_n), .i_wp_n(wp_n));
  sep_host host_u (.i_clk(clk), .i_so(so), .i_so_oe(so_oe), .o_cs_n(cs_n), .o_sck(sck), .o_si(si),
    .o_hold_n(hold_n));

  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic op1(input logic [7:0] op);
    host_u.sel();
    host_u.bx(op, 1'b0, r);
    host_u.desel();
  endtask : op1

  task automatic status_read_cmd();
    host_u.sel();
    host_u.bx(SEP_OP_STATUS_READ_CMD, 1'b0, r);
    host_u.bx(8'h00, 1'b0, s);
    host_u.desel();
  endtask : status_read_cmd

  task automatic status_write_cmd(input logic [7:0] v);
    host_u.sel();
    host_u.bx(SEP_OP_STATUS_WRITE_CMD, 1'b0, r);
    host_u.bx(v, 1'b0, r);
    host_u.desel();
  endtask : status_write_cmd

  task automatic wr(input logic [7:0] hi, input logic [7:0] lo, input int n, input logic [7:0] d);
    host_u.sel();
    host_u.bx(SEP_OP_WRITE, 1'b0, r);
    host_u.bx(hi, 1'b0, r);
    host_u.bx(lo, 1'b0, r);
    for (int k = 0; k < n; k++) host_u.bx(d + 8'(k), 1'b0, r);
    host_u.desel();
  endtask : wr

  task automatic wait_rdy();
    status_read_cmd();
    for (int k = 0; k < 20 && s[0] !== 1'b0; k++) status_read_cmd();
    status_read_cmd();
  endtask : wait_rdy

  task automatic t_rst2();
    op1(SEP_OP_SETWL);
    @(negedge clk);
    srst = 1'b1;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    status_read_cmd();
    chk(s, 8'h00);
  endtask : t_rst2

  task automatic t_mode3();
    host_u.cpol = 1'b1;
    op1(SEP_OP_SETWL);
    status_read_cmd();
    chk(s, 8'h02);
    op1(SEP_OP_CLRWL);
    host_u.sel();
    host_u.bx(SEP_OP_READ, 1'b0, r);
    host_u.bx(8'h00, 1'b0, r);
    host_u.bx(8'hE0, 1'b0, r);
    for (int k = 0; k < 2; k++) begin
      host_u.bx(8'h00, 1'b0, r);
      chk(r, 8'h30 + 8'(k));
    end
    host_u.desel();
    status_read_cmd();
    chk(s, 8'h00);
    host_u.cpol = 1'b0;
  endtask : t_mode3

  task automatic t_reset();
    status_read_cmd();
    chk(s, 8'h00);
    chk({7'h00, so_oe}, 8'h00);
  endtask : t_reset

  task automatic t_latch();
    op1(SEP_OP_SETWL);
    status_read_cmd();
    chk(s, 8'h02);
    op1(SEP_OP_CLRWL);
    status_read_cmd();
    chk(s, 8'h00);
    host_u.sel();
    host_u.bx(SEP_OP_SETWL, 1'b0, r);
    host_u.bx(8'h00, 1'b0, r);
    host_u.desel();
    status_read_cmd();
    chk(s, 8'h00);
    host_u.sel();
    host_u.bx(8'hFF, 1'b0, r);
    host_u.bx(8'h00, 1'b0, r);
    host_u.desel();
    chk(r, 8'hZZ);
  endtask : t_latch

  task automatic t_pause();
    host_u.sel();
    host_u.bx(SEP_OP_STATUS_READ_CMD, 1'b1, r);
    host_u.bx(8'h00, 1'b1, s);
    host_u.desel();
    chk(s, 8'h00);
  endtask : t_pause

  task automatic t_page();
    op1(SEP_OP_SETWL);
    wr(8'hF0, 8'hE0, 34, 8'h10);
    status_read_cmd();
    chk(s, 8'h03);
    op1(SEP_OP_CLRWL);
    status_read_cmd();
    chk(s, 8'h03);
    wait_rdy();
    chk(s, 8'h00);
    host_u.sel();
    host_u.bx(SEP_OP_READ, 1'b0, r);
    host_u.bx(8'h00, 1'b0, r);
    host_u.bx(8'hE0, 1'b0, r);
    for (int k = 0; k < 32; k++) begin
      host_u.bx(8'h00, 1'b0, r);
      chk(r, 8'(k) + (k < 2 ? 8'h30 : 8'h10));
    end
    host_u.desel();
  endtask : t_page

  task automatic t_protect();
    op1(SEP_OP_SETWL);
    status_write_cmd(8'hFF);
    wait_rdy();
    chk(s, 8'h8C);
    for (int b = 1; b < 4; b++) begin
      op1(SEP_OP_SETWL);
      status_write_cmd({4'h8, 2'(b), 2'h0});
      wait_rdy();
      op1(SEP_OP_SETWL);
      wr(b == 1 ? 8'h0C : (b == 2 ? 8'h08 : 8'h00), 8'h00, 1, 8'h55);
      status_read_cmd();
      chk(s, {4'h8, 2'(b), 2'h2});
    end
    @(negedge clk);
    wp_n = 1'b0;
    status_write_cmd(8'h00);
    status_read_cmd();
    chk(s, 8'h8E);
    @(negedge clk);
    wp_n = 1'b1;
    status_write_cmd(8'h00);
    wait_rdy();
    chk(s, 8'h00);
    wr(8'h00, 8'h00, 1, 8'hAA);
    status_read_cmd();
    chk(s, 8'h00);
    op1(SEP_OP_SETWL);
    wr(8'h00, 8'h00, 0, 8'h00);
    status_read_cmd();
    chk(s, 8'h02);
  endtask : t_protect

  // Main sequence
  initial begin
    srst = 1'b1;
    wp_n = 1'b1;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset();
    t_latch();
    t_rst2();
    t_pause();
    t_page();
    t_mode3();
    t_protect();
    give_verdict();
  end
endmodule : spi_serial_eeprom_protocol_bench
